// *** hdl/smmcg_pkg.sv ***
// Package of constants and types for the secure module mode command gate.
package smmcg_pkg;

	// Operating modes of the module.
	typedef enum logic [2:0] {
		SMMCG_BOOT     = 3'h0,
		SMMCG_RESTRICT = 3'h1,
		SMMCG_FULL     = 3'h2,
		SMMCG_SHUTDOWN = 3'h3,
		SMMCG_FAILURE  = 3'h4,
		SMMCG_REDUCED  = 3'h5
	} smmcg_mode_t;

	// Command classes as decoded by the command parser in front of this gate.
	typedef enum logic [3:0] {
		SMMCG_CMD_OTHER       = 4'h0,
		SMMCG_CMD_GETCAP      = 4'h1,
		SMMCG_CMD_GETTEST     = 4'h2,
		SMMCG_CMD_SELFTEST    = 4'h3,
		SMMCG_CMD_STARTUP     = 4'h4,
		SMMCG_CMD_UPD_BEGIN   = 4'h5,
		SMMCG_CMD_UPD_CHUNK   = 4'h6,
		SMMCG_CMD_KEYGEN      = 4'h7,
		SMMCG_CMD_ZEROIZE     = 4'h8,
		SMMCG_CMD_PLAINTEXT   = 4'h9,
		SMMCG_CMD_DATA        = 4'hA
	} smmcg_cmd_t;

	// Self-test bit positions in the test vectors.
	localparam int SMMCG_T_SHS   = 0;
	localparam int SMMCG_T_HMAC  = 1;
	localparam int SMMCG_T_AES   = 2;
	localparam int SMMCG_T_DRBG  = 3;
	localparam int SMMCG_T_KDF   = 4;
	localparam int SMMCG_T_TDES  = 5;
	localparam int SMMCG_T_HWI   = 6;
	localparam int SMMCG_T_FWI   = 7;
	localparam int SMMCG_T_NDRNG = 8;
	localparam int SMMCG_T_RSA   = 9;
	localparam int SMMCG_T_ECDH  = 10;
	localparam int SMMCG_T_ECDSA = 11;
	localparam int SMMCG_NTESTS  = 12;

	// Test sets run in the restricted mode and added in the full mode.
	localparam logic [11:0] SMMCG_SET_RESTRICT = 12'h1FF;
	localparam logic [11:0] SMMCG_SET_FULL     = 12'hFFF;
	localparam logic [11:0] SMMCG_TESTS_RST    = 12'h000;

	// Error codes returned by the gate.
	localparam logic [11:0] SMMCG_RC_SUCCESS      = 12'h000;
	localparam logic [11:0] SMMCG_RC_FAILURE      = 12'h101;
	localparam logic [11:0] SMMCG_RC_LEGACY_FAIL  = 12'h01C;
	localparam logic [11:0] SMMCG_RC_COMMAND_CODE = 12'h143;

	// Command request carried from the parser.
	typedef struct packed {
		smmcg_cmd_t cmd;
		logic       legacy;
		logic       full_test;
		logic       restore_fw;
		logic       struct_ok;
		logic       auth_ok;
		logic       blob_ok;
	} smmcg_req_t;

	// Response status sent back to the output framer.
	typedef struct packed {
		logic        accept;
		logic [11:0] code;
		logic        has_data;
	} smmcg_rsp_t;

endpackage : smmcg_pkg

// *** hdl/smmcg_gate.sv ***
// Operating-mode state machine and command gate of the secure module.
//
// Notes on behaviour
// - Power-up enters restricted mode, limited services.
// - Full mode only after full self-test command.
// - Restricted mode runs the nine basic self-tests.
// - Full mode adds signature and key-agreement tests.
// - Boot firmware check failure loops reset until a power cycle.
// - Any self-test failure other than firmware integrity enters failure mode.
// - Failure mode accepts capability, test-result, legacy startup.
// - Failure mode rejects others with 0x101 or 0x1C.
// - Failed firmware upgrade commands enter reduced mode.
// - Reduced mode allows update, query, self-test; else 0x143.
// - Successful restoring update-begin leaves reduced mode.
// - Key generation or zeroize gates data, keeps status.
// - Data path connects only for data-carrying responses.
// - No data output during error or self-test.
// - Inputs separated by per-command structure parsing.
// - Outputs separated by per-command response structure.
// - Plaintext needs structure, authorization, blob decrypt checks.
`timescale 1ns/1ns
`default_nettype none

module smmcg_gate (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rstn_i,
	input  wire logic                  por_i,
	input  wire logic                  boot_done_i,
	input  wire logic                  boot_fw_ok_i,
	input  wire logic                  req_valid_i,
	input  wire smmcg_pkg::smmcg_req_t req_i,
	input  wire logic                  test_done_i,
	input  wire logic [11:0]           test_fail_i,
	input  wire logic                  upd_error_i,
	input  wire logic                  upd_ok_i,
	input  wire logic                  busy_i,
	output logic                       rsp_valid_o,
	output smmcg_pkg::smmcg_rsp_t      rsp_o,
	output logic                       data_en_o,
	output logic                       status_en_o,
	output logic                       test_start_o,
	output logic [11:0]                test_set_o,
	output logic                       hw_reset_o,
	output logic [2:0]                 mode_o
);
	import smmcg_pkg::*;

	// Two-stage synchronisers for the asynchronous power-on and boot inputs.
	logic [1:0]  por_sync_ff;
	logic [1:0]  bdone_sync_ff;
	logic [1:0]  bfw_sync_ff;
	logic        por_q;
	logic        bdone_q;
	logic        bfw_q;
	logic        por_d_ff;

	smmcg_mode_t mode_ff;
	smmcg_mode_t nxt_mode;
	logic        testing_ff;
	logic        keyop_ff;
	logic        rsp_valid_ff;
	smmcg_rsp_t  rsp_ff;
	smmcg_rsp_t  nxt_rsp;
	logic        data_en_ff;
	logic        test_start_ff;
	logic [11:0] test_set_ff;
	logic        hw_reset_ff;
	logic        err_state;
	logic        full_req;
	logic        por_rise;

	// Synchroniser flops; first stages feed only the second stages.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			por_sync_ff   <= 2'h3; // Idle power level is high.
			bdone_sync_ff <= 2'h0;
			bfw_sync_ff   <= 2'h0;
		end else begin
			por_sync_ff   <= {por_sync_ff[0], por_i};
			bdone_sync_ff <= {bdone_sync_ff[0], boot_done_i};
			bfw_sync_ff   <= {bfw_sync_ff[0], boot_fw_ok_i};
		end
	end
	assign por_q   = por_sync_ff[1];
	assign bdone_q = bdone_sync_ff[1];
	assign bfw_q   = bfw_sync_ff[1];

	// Delayed power-on level; it resets high so leaving reset is never taken for a new power cycle.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			por_d_ff <= 1'b1;
		end else begin
			por_d_ff <= por_q;
		end
	end

	// Mode is an error state in shutdown and failure.
	assign err_state = (mode_ff == SMMCG_FAILURE) || (mode_ff == SMMCG_SHUTDOWN);
	assign full_req  = req_valid_i && (req_i.cmd == SMMCG_CMD_SELFTEST) && req_i.full_test;
	assign por_rise  = por_q && !por_d_ff;

	// Returns one when a command is allowed in the given mode.
	function automatic logic cmd_allowed(input smmcg_mode_t m, input smmcg_req_t r);
		logic ok;
		ok = 1'b0;
		unique case (m)
			SMMCG_FAILURE: begin
				ok = (r.cmd == SMMCG_CMD_GETCAP) || (r.cmd == SMMCG_CMD_GETTEST) ||
				     (r.legacy && (r.cmd == SMMCG_CMD_STARTUP));
			end
			SMMCG_REDUCED: begin
				ok = (r.cmd == SMMCG_CMD_UPD_BEGIN) || (r.cmd == SMMCG_CMD_UPD_CHUNK) ||
				     (r.cmd == SMMCG_CMD_GETCAP) || (r.cmd == SMMCG_CMD_GETTEST) ||
				     (r.cmd == SMMCG_CMD_SELFTEST);
			end
			SMMCG_RESTRICT: begin
				ok = (r.cmd != SMMCG_CMD_KEYGEN) && (r.cmd != SMMCG_CMD_PLAINTEXT);
			end
			SMMCG_FULL: begin
				ok = 1'b1;
			end
			SMMCG_BOOT, SMMCG_SHUTDOWN: begin
				ok = 1'b0;
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction

	// Returns one when any self-test other than firmware integrity failed.
	function automatic logic test_failed(input logic [11:0] f);
		return (f & ~(12'h001 << SMMCG_T_FWI)) != 12'h000;
	endfunction

	// Next mode decision.
	always_comb begin
		nxt_mode = mode_ff;
		unique case (mode_ff)
			SMMCG_BOOT: begin
				if (bdone_q && !bfw_q) begin
					nxt_mode = SMMCG_SHUTDOWN;
				end else if (bdone_q) begin
					nxt_mode = SMMCG_RESTRICT;
				end
			end
			SMMCG_SHUTDOWN: begin
				if (por_rise) begin
					nxt_mode = SMMCG_BOOT;
				end
			end
			SMMCG_RESTRICT, SMMCG_FULL: begin
				if (testing_ff && test_done_i && test_failed(test_fail_i)) begin
					nxt_mode = SMMCG_FAILURE;
				end else if (testing_ff && test_done_i && test_fail_i == 12'h000 &&
				             test_set_ff == SMMCG_SET_FULL) begin
					nxt_mode = SMMCG_FULL;
				end else if (upd_error_i) begin
					nxt_mode = SMMCG_REDUCED;
				end
			end
			SMMCG_REDUCED: begin
				if (upd_ok_i && req_i.cmd == SMMCG_CMD_UPD_BEGIN && req_i.restore_fw) begin
					nxt_mode = SMMCG_RESTRICT;
				end else if (testing_ff && test_done_i && test_failed(test_fail_i)) begin
					nxt_mode = SMMCG_FAILURE;
				end
			end
			SMMCG_FAILURE: begin
				nxt_mode = SMMCG_FAILURE;
			end
			default: begin
				nxt_mode = SMMCG_BOOT;
			end
		endcase
	end

	// Mode register; a power cycle restarts the boot sequence from any mode.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_ff <= SMMCG_BOOT;
		end else if (por_rise) begin
			mode_ff <= SMMCG_BOOT;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// Self-test launch: the set depends on the mode and the full request.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			testing_ff    <= 1'b0;
			test_start_ff <= 1'b0;
			test_set_ff   <= SMMCG_TESTS_RST;
		end else begin
			test_start_ff <= 1'b0;
			if (testing_ff && test_done_i) begin
				testing_ff <= 1'b0;
			end else if (!testing_ff && req_valid_i && req_i.cmd == SMMCG_CMD_SELFTEST &&
			             cmd_allowed(mode_ff, req_i)) begin
				testing_ff    <= 1'b1;
				test_start_ff <= 1'b1;
				if (full_req || mode_ff == SMMCG_FULL) begin
					test_set_ff <= SMMCG_SET_FULL;
				end else begin
					test_set_ff <= SMMCG_SET_RESTRICT;
				end
			end
		end
	end

	// Key generation or zeroization marks the data path busy.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			keyop_ff <= 1'b0;
		end else if (req_valid_i && (req_i.cmd == SMMCG_CMD_KEYGEN || req_i.cmd == SMMCG_CMD_ZEROIZE) &&
		             cmd_allowed(mode_ff, req_i)) begin
			keyop_ff <= 1'b1;
		end else if (!busy_i) begin
			keyop_ff <= 1'b0;
		end
	end

	// Response builder: acceptance and error code from the mode filter.
	always_comb begin
		nxt_rsp          = '0;
		nxt_rsp.code     = SMMCG_RC_SUCCESS;
		nxt_rsp.accept   = cmd_allowed(mode_ff, req_i);
		if (!nxt_rsp.accept) begin
			if (mode_ff == SMMCG_FAILURE) begin
				nxt_rsp.code = req_i.legacy ? SMMCG_RC_LEGACY_FAIL : SMMCG_RC_FAILURE;
			end else begin
				nxt_rsp.code = SMMCG_RC_COMMAND_CODE;
			end
		end else if (req_i.cmd == SMMCG_CMD_PLAINTEXT &&
		             !(req_i.struct_ok && req_i.auth_ok && req_i.blob_ok)) begin
			nxt_rsp.accept = 1'b0;
			nxt_rsp.code   = SMMCG_RC_FAILURE;
		end
		nxt_rsp.has_data = nxt_rsp.accept &&
		                   (req_i.cmd == SMMCG_CMD_PLAINTEXT || req_i.cmd == SMMCG_CMD_DATA ||
		                    req_i.cmd == SMMCG_CMD_GETCAP || req_i.cmd == SMMCG_CMD_GETTEST);
	end

	// Response register and output path enables.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rsp_valid_ff <= 1'b0;
			rsp_ff       <= '0;
			data_en_ff   <= 1'b0;
		end else begin
			rsp_valid_ff <= req_valid_i && (mode_ff != SMMCG_BOOT) && (mode_ff != SMMCG_SHUTDOWN);
			rsp_ff       <= nxt_rsp;
			data_en_ff   <= req_valid_i && nxt_rsp.has_data && !err_state && !testing_ff &&
			                !keyop_ff;
		end
	end

	// Shutdown mode drives the hardware reset loop.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hw_reset_ff <= 1'b0;
		end else begin
			hw_reset_ff <= (nxt_mode == SMMCG_SHUTDOWN) && !por_rise;
		end
	end

	// Outputs come straight from flops; status path enabled with every valid response.
	assign rsp_valid_o  = rsp_valid_ff;
	assign rsp_o        = rsp_ff;
	assign data_en_o    = data_en_ff;
	assign status_en_o  = rsp_valid_ff;
	assign test_start_o = test_start_ff;
	assign test_set_o   = test_set_ff;
	assign hw_reset_o   = hw_reset_ff;
	assign mode_o       = mode_ff;

	// Checks of the mode and output behaviour.
	a_fail_code: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		req_valid_i && mode_ff == SMMCG_FAILURE && req_i.cmd == SMMCG_CMD_OTHER && !req_i.legacy
		|=> rsp_valid_o && rsp_o.code == SMMCG_RC_FAILURE)
		else $error("failure mode code wrong");
	a_legacy_code: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		req_valid_i && mode_ff == SMMCG_FAILURE && req_i.cmd == SMMCG_CMD_OTHER && req_i.legacy
		|=> rsp_o.code == SMMCG_RC_LEGACY_FAIL)
		else $error("legacy failure code wrong");
	a_fail_allow: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		req_valid_i && mode_ff == SMMCG_FAILURE && req_i.cmd == SMMCG_CMD_GETCAP |=> rsp_o.accept)
		else $error("capability refused in failure mode");
	a_reduced_code: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		req_valid_i && mode_ff == SMMCG_REDUCED && req_i.cmd == SMMCG_CMD_OTHER
		|=> rsp_o.code == SMMCG_RC_COMMAND_CODE)
		else $error("reduced mode code wrong");
	a_no_data_err: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$past(err_state) || $past(testing_ff) |-> !data_en_o)
		else $error("data during error or test");
	a_keyop_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		keyop_ff |=> !data_en_o)
		else $error("data during key operation");
	a_data_only: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		data_en_o |-> rsp_o.has_data && rsp_valid_o)
		else $error("data path without data response");
	a_shutdown_rst: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		mode_ff == SMMCG_SHUTDOWN && !por_rise |=> hw_reset_o)
		else $error("reset loop not driven");
	a_shut_silent: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		mode_ff == SMMCG_SHUTDOWN |=> !rsp_valid_o)
		else $error("response given in shutdown");
	a_full_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$changed(mode_ff) && mode_ff == SMMCG_FULL |-> $past(test_set_ff) == SMMCG_SET_FULL)
		else $error("full mode without full test");
	a_plain_chk: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		req_valid_i && req_i.cmd == SMMCG_CMD_PLAINTEXT && !req_i.auth_ok |=> !rsp_o.accept)
		else $error("plaintext released without auth");
	a_boot_enter: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		mode_ff == SMMCG_BOOT && bdone_q && bfw_q && !por_rise |=> mode_ff == SMMCG_RESTRICT)
		else $error("boot did not enter restricted mode");
	a_power_cycle: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		por_rise |=> mode_ff == SMMCG_BOOT && !hw_reset_o)
		else $error("power cycle did not restart boot");
	a_restrict_set: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		req_valid_i && mode_ff == SMMCG_RESTRICT && req_i.cmd == SMMCG_CMD_SELFTEST &&
		!req_i.full_test && !testing_ff |=> test_start_o && test_set_o == SMMCG_SET_RESTRICT)
		else $error("restricted self-test set wrong");
	a_full_set: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		req_valid_i && mode_ff == SMMCG_FULL && req_i.cmd == SMMCG_CMD_SELFTEST && !testing_ff
		|=> test_start_o && test_set_o == SMMCG_SET_FULL)
		else $error("full mode self-test set wrong");
	a_fail_entry: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		mode_ff != SMMCG_BOOT && mode_ff != SMMCG_SHUTDOWN && testing_ff && test_done_i &&
		test_failed(test_fail_i) && !upd_ok_i && !por_rise |=> mode_ff == SMMCG_FAILURE)
		else $error("self-test failure missed");
	a_reduced_exit: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		mode_ff == SMMCG_REDUCED && upd_ok_i && req_i.cmd == SMMCG_CMD_UPD_BEGIN &&
		req_i.restore_fw && !por_rise |=> mode_ff == SMMCG_RESTRICT)
		else $error("reduced mode not left after restore");
	c_full: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) mode_ff == SMMCG_FULL);
	c_fail: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) mode_ff == SMMCG_FAILURE);
	c_reduced_exit: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
		mode_ff == SMMCG_REDUCED ##1 mode_ff == SMMCG_RESTRICT);
	c_shutdown: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) hw_reset_o);
	c_keyop_data: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
		keyop_ff && req_valid_i && req_i.cmd == SMMCG_CMD_DATA);

endmodule : smmcg_gate

`default_nettype wire

// *** tb/smmcg_host.sv ***
// Host controller model that issues parsed commands to the mode gate.
`timescale 1ns/1ns
`default_nettype none
module smmcg_host (
	input  wire logic                  ref_clk_i,
	input  wire logic                  hold_i,
	input  wire logic                  rsp_valid_i,
	input  wire smmcg_pkg::smmcg_rsp_t rsp_i,
	output logic                       req_valid_o,
	output smmcg_pkg::smmcg_req_t      req_o
);
	import smmcg_pkg::*;
	logic       got;
	smmcg_rsp_t rsp;
	// Idle request lines start low.
	initial begin
		req_valid_o = 1'b0;
		req_o = '0;
		got = 1'b0;
		rsp = '0;
	end
	// One request pulse, then the answer is taken one cycle later.
	task send(input smmcg_cmd_t c, input logic lg, input logic ft, input logic rf, input logic ok);
		@(posedge ref_clk_i);
		#1;
		req_valid_o = 1'b1;
		req_o = '{c, lg, ft, rf, 1'b1, ok, ok};
		@(posedge ref_clk_i);
		#1;
		req_valid_o = 1'b0;
		// Unless hold_i is set, released lines show the inverse so a stale command never looks valid.
		if (!hold_i) begin
			req_o = ~req_o;
		end
		got = rsp_valid_i;
		rsp = rsp_i;
	endtask
endmodule // smmcg_host
`default_nettype wire

// *** tb/smmcg_gate_tb_top.sv ***
// Self-checking testbench of the mode gate.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch %s exp %0h got %0h", n, e, g); end end
module smmcg_gate_tb_top;
	import smmcg_pkg::*;
	logic        clk, rstn, por, bdone, fwok, tdone, uerr, uok, busy, hold;
	logic [11:0] tfail, tset;
	logic        req_v, rsp_v, den, sen, tstart, hwrst;
	logic [2:0]  mode;
	smmcg_req_t  req;
	smmcg_rsp_t  rsp;
	int          err_total, checked, cyc;
	smmcg_gate u_smmcg_gate (.ref_clk_i(clk), .rstn_i(rstn), .por_i(por), .boot_done_i(bdone),
		.boot_fw_ok_i(fwok), .req_valid_i(req_v), .req_i(req), .test_done_i(tdone), .test_fail_i(tfail),
		.upd_error_i(uerr), .upd_ok_i(uok), .busy_i(busy), .rsp_valid_o(rsp_v), .rsp_o(rsp),
		.data_en_o(den), .status_en_o(sen), .test_start_o(tstart), .test_set_o(tset),
		.hw_reset_o(hwrst), .mode_o(mode));
	smmcg_host u_smmcg_host (.ref_clk_i(clk), .hold_i(hold), .rsp_valid_i(rsp_v), .rsp_i(rsp),
		.req_valid_o(req_v), .req_o(req));
	// Clock at 100 MHz.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Prints the counts and the verdict, then ends the run.
	task results();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			results();
		end
	end
	// Holds reset for 20 cycles with the given boot integrity outcome.
	task do_reset(input logic fw);
		@(posedge clk);
		#1;
		rstn = 1'b0;
		fwok = fw;
		repeat (20) @(posedge clk);
		#1;
		rstn = 1'b1;
	endtask
	// Waits a bounded time for a mode, then compares it.
	task wmode(input logic [2:0] m);
		for (int i = 0; i < 30 && mode !== m; i++) begin
			@(posedge clk);
			#1;
		end
		`CHK("mode", m, mode)
	endtask
	// Compares the answer just taken by the host.
	task chk(input logic a, input logic [11:0] cd, input logic d);
		`CHK("rsp_valid", 1'b1, u_smmcg_host.got)
		`CHK("status_en", 1'b1, sen)
		`CHK("accept", a, u_smmcg_host.rsp.accept)
		if (!a) `CHK("code", cd, u_smmcg_host.rsp.code)
		`CHK("data_en", d, den)
	endtask
	// Ends a self-test run with the given failure bits.
	task tend(input logic [11:0] f);
		@(posedge clk);
		#1;
		tdone = 1'b1;
		tfail = f;
		@(posedge clk);
		#1;
		tdone = 1'b0;
		tfail = '0;
		@(posedge clk);
		#1;
	endtask
	// Restricted mode, partial and full self-test, move to full mode.
	task t_restrict();
		wmode(3'h1);
		u_smmcg_host.send(SMMCG_CMD_GETCAP, 0, 0, 0, 1);
		chk(1'b1, 12'h000, 1'b1);
		u_smmcg_host.send(SMMCG_CMD_KEYGEN, 0, 0, 0, 1);
		`CHK("restricted_keygen", 1'b0, u_smmcg_host.rsp.accept)
		u_smmcg_host.send(SMMCG_CMD_SELFTEST, 0, 0, 0, 1);
		`CHK("test_start", 1'b1, tstart)
		`CHK("test_set", SMMCG_SET_RESTRICT, tset)
		u_smmcg_host.send(SMMCG_CMD_GETCAP, 0, 0, 0, 1);
		chk(1'b1, 12'h000, 1'b0);
		`CHK("has_data", 1'b1, u_smmcg_host.rsp.has_data)
		tend(12'h000);
		wmode(3'h1);
		u_smmcg_host.send(SMMCG_CMD_SELFTEST, 0, 1, 0, 1);
		`CHK("test_set", SMMCG_SET_FULL, tset)
		tend(12'h000);
		wmode(3'h2);
	endtask
	// Full mode tests, key operations and plaintext checks.
	task t_full();
		smmcg_cmd_t kc[2];
		kc = '{SMMCG_CMD_KEYGEN, SMMCG_CMD_ZEROIZE};
		u_smmcg_host.send(SMMCG_CMD_SELFTEST, 0, 0, 0, 1);
		`CHK("test_set", SMMCG_SET_FULL, tset)
		tend(12'h000);
		foreach (kc[i]) begin
			busy = 1'b1;
			u_smmcg_host.send(kc[i], 0, 0, 0, 1);
			chk(1'b1, 12'h000, 1'b0);
			u_smmcg_host.send(SMMCG_CMD_DATA, 0, 0, 0, 1);
			chk(1'b1, 12'h000, 1'b0);
			busy = 1'b0;
			u_smmcg_host.send(SMMCG_CMD_DATA, 0, 0, 0, 1);
			chk(1'b1, 12'h000, 1'b1);
		end
		u_smmcg_host.send(SMMCG_CMD_OTHER, 0, 0, 0, 1);
		chk(1'b1, 12'h000, 1'b0);
		u_smmcg_host.send(SMMCG_CMD_PLAINTEXT, 0, 0, 0, 0);
		chk(1'b0, SMMCG_RC_FAILURE, 1'b0);
		u_smmcg_host.send(SMMCG_CMD_PLAINTEXT, 0, 0, 0, 1);
		chk(1'b1, 12'h000, 1'b1);
	endtask
	// Reduced mode after an upgrade error, and the way out of it.
	task t_reduced();
		smmcg_cmd_t ok_c[5];
		ok_c = '{SMMCG_CMD_UPD_BEGIN, SMMCG_CMD_UPD_CHUNK, SMMCG_CMD_GETCAP, SMMCG_CMD_GETTEST, SMMCG_CMD_SELFTEST};
		uerr = 1'b1;
		@(posedge clk);
		#1;
		uerr = 1'b0;
		wmode(3'h5);
		foreach (ok_c[i]) begin
			u_smmcg_host.send(ok_c[i], 0, 0, 0, 1);
			`CHK("reduced_accept", 1'b1, u_smmcg_host.rsp.accept)
		end
		tend(12'h000);
		u_smmcg_host.send(SMMCG_CMD_OTHER, 0, 0, 0, 1);
		chk(1'b0, SMMCG_RC_COMMAND_CODE, 1'b0);
		hold = 1'b1;
		u_smmcg_host.send(SMMCG_CMD_UPD_BEGIN, 0, 0, 1, 1);
		uok = 1'b1;
		@(posedge clk);
		#1;
		uok = 1'b0;
		hold = 1'b0;
		@(posedge clk);
		#1;
		`CHK("left_reduced", 3'h1, mode)
	endtask
	// Failure mode entry and its command filter.
	task t_failure();
		smmcg_cmd_t  fc[6];
		logic [5:0]  lg, ac;
		logic [11:0] cd[6];
		fc = '{SMMCG_CMD_GETCAP, SMMCG_CMD_GETTEST, SMMCG_CMD_STARTUP, SMMCG_CMD_STARTUP, SMMCG_CMD_OTHER, SMMCG_CMD_DATA};
		lg = 6'h14;
		ac = 6'h07;
		cd = '{12'h000, 12'h000, 12'h000, 12'h101, 12'h01C, 12'h101};
		do_reset(1'b1);
		wmode(3'h1);
		u_smmcg_host.send(SMMCG_CMD_SELFTEST, 0, 1, 0, 1);
		tend(12'h080);
		`CHK("fw_fail_no_failure", 3'h1, mode)
		u_smmcg_host.send(SMMCG_CMD_SELFTEST, 0, 1, 0, 1);
		tend(12'h001);
		wmode(3'h4);
		for (int i = 0; i < 6; i++) begin
			u_smmcg_host.send(fc[i], lg[i], 0, 0, 1);
			chk(ac[i], cd[i], 1'b0);
		end
	endtask
	// Boot integrity failure loops in shutdown until power is cycled.
	task t_shutdown();
		do_reset(1'b0);
		wmode(3'h3);
		`CHK("hw_reset", 1'b1, hwrst)
		u_smmcg_host.send(SMMCG_CMD_GETCAP, 0, 0, 0, 1);
		`CHK("no_rsp", 1'b0, u_smmcg_host.got)
		fwok = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		`CHK("still_shutdown", 3'h3, mode)
		por = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		por = 1'b1;
		wmode(3'h1);
	endtask
	// Main sequence.
	initial begin
		{rstn, tdone, uerr, uok, busy, hold} = '0;
		{por, bdone, fwok} = 3'h7;
		tfail = '0;
		err_total = 0;
		checked = 0;
		cyc = 0;
		do_reset(1'b1);
		t_restrict();
		t_full();
		t_reduced();
		t_failure();
		t_shutdown();
		results();
	end
endmodule // smmcg_gate_tb_top
`default_nettype wire
